/* File: common/poe_status_pkg.sv */
// constants, codes and carriers for the per-port status and result registers
// What this block does
// - register 0101 per port is read-only status; bits 7 to 5 read zero.
// - bit 4 shows watchdog active, bit 3 conversion busy; both zero otherwise.
// - bits 2 to 0 give port state code 000 to 101; reset to 000.
// - register 0110 gives discovery-current result bits 7 to 0, read-only.
// - register 0111 gives result bits 14 to 8 plus complete flag in bit 7.
// - complete flag clears on discovery start, sets when its conversion ends.
// - register 1000 gives voltage result bits 7 to 0, read-only.
// - register 1001 gives voltage bits 14 to 8; bit 7 low while converting.
package poe_status_pkg;

  localparam int NUM_PORTS = 4;
  localparam int SEL_W = 4;
  localparam int DATA_W = 8;
  localparam int RESULT_W = 15;
  localparam int FUNC_W = 4;
  localparam int STATE_W = 3;

  // register select codes
  localparam logic [SEL_W-1:0] SEL_STATUS2 = 4'h5;
  localparam logic [SEL_W-1:0] SEL_DISC_LO = 4'h6;
  localparam logic [SEL_W-1:0] SEL_DISC_HI = 4'h7;
  localparam logic [SEL_W-1:0] SEL_VOLT_LO = 4'h8;
  localparam logic [SEL_W-1:0] SEL_VOLT_HI = 4'h9;

  // field positions in the status register and the result high registers
  localparam int BIT_WATCHDOG = 4;
  localparam int BIT_ADC_BUSY = 3;
  localparam int BIT_DONE_FLAG = 7;

  // reset values
  localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
  localparam logic [RESULT_W-1:0] RESULT_RESET = 15'h0000;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  // function codes written by the host
  localparam logic [FUNC_W-1:0] FUNC_DISC1 = 4'h1;
  localparam logic [FUNC_W-1:0] FUNC_DISC2 = 4'h2;

  // port state codes
  localparam logic [STATE_W-1:0] ST_DISABLED = 3'h0;
  localparam logic [STATE_W-1:0] ST_SEARCHING = 3'h1;
  localparam logic [STATE_W-1:0] ST_POWERED = 3'h2;
  localparam logic [STATE_W-1:0] ST_FAULT = 3'h3;
  localparam logic [STATE_W-1:0] ST_TEST = 3'h4;
  localparam logic [STATE_W-1:0] ST_OTHER_FAULT = 3'h5;

  typedef enum logic [1:0] {
    CONV_NONE,
    CONV_DISC,
    CONV_VOLT,
    CONV_OTHER
  } conv_kind_t;

  // events from the port's own control logic; func_wr, volt_start and conv_done are one-cycle pulses
  typedef struct packed {
    logic watchdog_active;
    logic adc_busy;
    logic [STATE_W-1:0] port_state;
    logic func_wr;
    logic [FUNC_W-1:0] func_code;
    logic volt_start;
    logic conv_done;
    conv_kind_t conv_kind;
    logic [RESULT_W-1:0] conv_result;
  } port_evt_t;

  typedef struct packed {
    logic [DATA_W-1:0] status;
    logic disc_flag;
    logic [RESULT_W-1:0] disc_result;
    logic volt_flag;
    logic [RESULT_W-1:0] volt_result;
  } port_regs_t;

endpackage : poe_status_pkg

/* File: rtl/poe_port_status_adc_results.sv */
// per-port status and conversion result register bank with select-code read port
`timescale 1ns/1ps
module poe_port_status_adc_results #(
  parameter int NUM_PORTS = poe_status_pkg::NUM_PORTS
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // per-port events from port control logic
  input poe_status_pkg::port_evt_t evt_i [NUM_PORTS],
  // register access from the serial engine
  input wire logic [$clog2(NUM_PORTS)-1:0] port_sel_i,
  input wire logic [poe_status_pkg::SEL_W-1:0] reg_sel_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [poe_status_pkg::DATA_W-1:0] wr_data_i,
  // read answer and write acknowledge
  output logic [poe_status_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic wr_ack_o
);

  poe_status_pkg::port_regs_t regs [NUM_PORTS];
  poe_status_pkg::port_regs_t sel_regs;
  logic [poe_status_pkg::DATA_W-1:0] rd_data_nxt;
  logic [poe_status_pkg::DATA_W-1:0] rd_data_r;
  logic rd_valid_r;
  logic wr_ack_r;
  logic mapped;
  logic [4:0] live_status_d [NUM_PORTS];

  // one register slice per port
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    port_result_slice u_slice (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .evt_i(evt_i[p]),
      .regs_o(regs[p])
    );

    // assertion helper: live status inputs one edge late
    always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
        live_status_d[p] <= 5'h00;
      end else begin
        live_status_d[p] <= {evt_i[p].watchdog_active, evt_i[p].adc_busy, evt_i[p].port_state};
      end
    end
  end

  assign sel_regs = regs[port_sel_i];

  // read decode by select code
  always_comb begin
    rd_data_nxt = poe_status_pkg::UNMAPPED_READ;
    mapped = 1'b1;
    if (reg_sel_i == poe_status_pkg::SEL_STATUS2) begin
      rd_data_nxt = sel_regs.status;
    end else if (reg_sel_i == poe_status_pkg::SEL_DISC_LO) begin
      rd_data_nxt = sel_regs.disc_result[7:0];
    end else if (reg_sel_i == poe_status_pkg::SEL_DISC_HI) begin
      rd_data_nxt = {sel_regs.disc_flag, sel_regs.disc_result[14:8]};
    end else if (reg_sel_i == poe_status_pkg::SEL_VOLT_LO) begin
      rd_data_nxt = sel_regs.volt_result[7:0];
    end else if (reg_sel_i == poe_status_pkg::SEL_VOLT_HI) begin
      rd_data_nxt = {sel_regs.volt_flag, sel_regs.volt_result[14:8]};
    end else begin
      mapped = 1'b0;
    end
  end

  // read data register, held until the next read
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_r <= poe_status_pkg::UNMAPPED_READ;
    end else if (rd_en_i) begin
      rd_data_r <= rd_data_nxt;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= rd_en_i;
    end
  end

  // writes are acknowledged and dropped; a write in the same cycle as a read gets no acknowledge
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ack_r <= 1'b0;
    end else begin
      wr_ack_r <= wr_en_i && !rd_en_i;
    end
  end

  assign rd_data_o = rd_data_r;
  assign rd_valid_o = rd_valid_r;
  assign wr_ack_o = wr_ack_r;

  property p_rd_status;
    @(posedge clock_i) disable iff (reset_i)
      rd_en_i && reg_sel_i == poe_status_pkg::SEL_STATUS2 |=>
        rd_valid_o && rd_data_o[7:5] == 3'h0 &&
        rd_data_o[4] == $past(regs[port_sel_i].status[poe_status_pkg::BIT_WATCHDOG]) &&
        rd_data_o[3] == $past(regs[port_sel_i].status[poe_status_pkg::BIT_ADC_BUSY]);
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status read wrong");

  property p_status_follow;
    @(posedge clock_i) disable iff (reset_i)
      rd_en_i && reg_sel_i == poe_status_pkg::SEL_STATUS2 |=>
        rd_data_o[4] == $past(live_status_d[port_sel_i][4]) &&
        rd_data_o[3] == $past(live_status_d[port_sel_i][3]);
  endproperty
  a_status_follow: assert property (p_status_follow) else $error("status bits do not follow port logic");

  property p_state_follow;
    @(posedge clock_i) disable iff (reset_i)
      rd_en_i && reg_sel_i == poe_status_pkg::SEL_STATUS2 |=>
        rd_data_o[2:0] == $past(live_status_d[port_sel_i][2:0]);
  endproperty
  a_state_follow: assert property (p_state_follow) else $error("port state code wrong");

  property p_rd_disc_lo;
    @(posedge clock_i) disable iff (reset_i)
      rd_en_i && reg_sel_i == poe_status_pkg::SEL_DISC_LO |=> rd_data_o == $past(regs[port_sel_i].disc_result[7:0]);
  endproperty
  a_rd_disc_lo: assert property (p_rd_disc_lo) else $error("discovery low byte wrong");

  property p_rd_disc_hi;
    @(posedge clock_i) disable iff (reset_i)
      rd_en_i && reg_sel_i == poe_status_pkg::SEL_DISC_HI |=>
        rd_data_o[6:0] == $past(regs[port_sel_i].disc_result[14:8]) &&
        rd_data_o[poe_status_pkg::BIT_DONE_FLAG] == $past(regs[port_sel_i].disc_flag);
  endproperty
  a_rd_disc_hi: assert property (p_rd_disc_hi) else $error("discovery high byte wrong");

  property p_rd_volt_lo;
    @(posedge clock_i) disable iff (reset_i)
      rd_en_i && reg_sel_i == poe_status_pkg::SEL_VOLT_LO |=> rd_data_o == $past(regs[port_sel_i].volt_result[7:0]);
  endproperty
  a_rd_volt_lo: assert property (p_rd_volt_lo) else $error("voltage low byte wrong");

  property p_rd_volt_hi;
    @(posedge clock_i) disable iff (reset_i)
      rd_en_i && reg_sel_i == poe_status_pkg::SEL_VOLT_HI |=>
        rd_data_o[6:0] == $past(regs[port_sel_i].volt_result[14:8]) &&
        rd_data_o[poe_status_pkg::BIT_DONE_FLAG] == $past(regs[port_sel_i].volt_flag);
  endproperty
  a_rd_volt_hi: assert property (p_rd_volt_hi) else $error("voltage high byte wrong");

  property p_unmapped;
    @(posedge clock_i) disable iff (reset_i)
      rd_en_i && !mapped |=> rd_valid_o && rd_data_o == poe_status_pkg::UNMAPPED_READ;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped select not read as zero");

  property p_wr_no_effect;
    @(posedge clock_i) disable iff (reset_i)
      wr_en_i && !rd_en_i |=> wr_ack_o && !rd_valid_o && $stable(rd_data_o);
  endproperty
  a_wr_no_effect: assert property (p_wr_no_effect) else $error("write disturbed read path");

endmodule : poe_port_status_adc_results

/* File: rtl/port_result_slice.sv */
// one port's status and result registers
`timescale 1ns/1ps
module port_result_slice (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // events from port logic
  input poe_status_pkg::port_evt_t evt_i,
  // register contents
  output poe_status_pkg::port_regs_t regs_o
);

  logic [poe_status_pkg::DATA_W-1:0] status_r;
  logic disc_active_r;
  logic disc_flag_r;
  logic [poe_status_pkg::RESULT_W-1:0] disc_result_r;
  logic volt_flag_r;
  logic [poe_status_pkg::RESULT_W-1:0] volt_result_r;
  logic disc_start;
  logic disc_done;
  logic volt_done;

  assign disc_start = evt_i.func_wr &&
    (evt_i.func_code == poe_status_pkg::FUNC_DISC1 || evt_i.func_code == poe_status_pkg::FUNC_DISC2);
  assign disc_done = evt_i.conv_done && evt_i.conv_kind == poe_status_pkg::CONV_DISC && disc_active_r;
  assign volt_done = evt_i.conv_done && evt_i.conv_kind == poe_status_pkg::CONV_VOLT;

  // status snapshot, top bits forced low
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      status_r <= poe_status_pkg::STATUS_RESET;
    end else begin
      status_r <= {3'h0, evt_i.watchdog_active, evt_i.adc_busy, evt_i.port_state};
    end
  end

  // discovery function in progress
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      disc_active_r <= 1'b0;
    end else if (evt_i.func_wr) begin
      disc_active_r <= disc_start;
    end else if (disc_done) begin
      disc_active_r <= 1'b0;
    end
  end

  // discovery complete flag, set wins over clear
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      disc_flag_r <= poe_status_pkg::FLAG_RESET;
    end else if (disc_done) begin
      disc_flag_r <= 1'b1;
    end else if (disc_start) begin
      disc_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      disc_result_r <= poe_status_pkg::RESULT_RESET;
    end else if (disc_done) begin
      disc_result_r <= evt_i.conv_result;
    end
  end

  // voltage complete flag, set wins over clear
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      volt_flag_r <= poe_status_pkg::FLAG_RESET;
    end else if (volt_done) begin
      volt_flag_r <= 1'b1;
    end else if (evt_i.volt_start) begin
      volt_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      volt_result_r <= poe_status_pkg::RESULT_RESET;
    end else if (volt_done) begin
      volt_result_r <= evt_i.conv_result;
    end
  end

  assign regs_o = '{status: status_r, disc_flag: disc_flag_r, disc_result: disc_result_r,
                    volt_flag: volt_flag_r, volt_result: volt_result_r};

  property p_disc_clear;
    @(posedge clock_i) disable iff (reset_i) disc_start && !disc_done |=> !disc_flag_r ##1 !disc_flag_r || $past(disc_done);
  endproperty
  a_disc_clear: assert property (p_disc_clear) else $error("discovery flag not cleared at start");

  property p_disc_set;
    @(posedge clock_i) disable iff (reset_i) disc_done |=> disc_flag_r && disc_result_r == $past(evt_i.conv_result);
  endproperty
  a_disc_set: assert property (p_disc_set) else $error("discovery flag or result not set at end");

  property p_volt_cycle;
    @(posedge clock_i) disable iff (reset_i) evt_i.volt_start && !volt_done ##1 !volt_done [*2] |=> !volt_flag_r;
  endproperty
  a_volt_cycle: assert property (p_volt_cycle) else $error("voltage flag high during conversion");

  property p_volt_set;
    @(posedge clock_i) disable iff (reset_i) volt_done |=> volt_flag_r && volt_result_r == $past(evt_i.conv_result);
  endproperty
  a_volt_set: assert property (p_volt_set) else $error("voltage flag or result not set at end");

  property p_hold;
    @(posedge clock_i) disable iff (reset_i) !disc_done && !volt_done |=> $stable(disc_result_r) && $stable(volt_result_r);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed without a conversion");

endmodule : port_result_slice

/* File: testbench/poe_port_status_adc_results_tb.sv */
// self-checking bench for the status and result register bank
`timescale 1ns/1ps
module poe_port_status_adc_results_tb;
  localparam int NP = poe_status_pkg::NUM_PORTS;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  poe_status_pkg::port_evt_t evt [NP];
  logic [1:0] port_sel = 2'h0;
  logic [3:0] reg_sel = 4'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] rd_data;
  logic rd_valid;
  logic wr_ack;
  logic [NP-1:0] c_func = '0;
  logic [NP-1:0] c_volt = '0;
  logic [NP-1:0] wd = '0;
  logic [3:0] c_code = 4'h1;
  logic [14:0] c_res = 15'h0000;
  logic [7:0] c_dly = 8'h00;
  logic [2:0] st [NP] = '{default: 3'h0};
  logic [14:0] dv [NP] = '{default: 15'h0000};
  logic [14:0] vv [NP] = '{default: 15'h0000};
  logic df [NP] = '{default: 1'b0};
  logic vf [NP] = '{default: 1'b0};
  logic [7:0] exp_q [$];
  int err_count = 0;
  int n_checks = 0;

  always #2.5 clock_i = ~clock_i;

  poe_port_status_adc_results uut (.clock_i(clock_i), .reset_i(reset_i), .evt_i(evt), .port_sel_i(port_sel),
    .reg_sel_i(reg_sel), .rd_en_i(rd_en), .wr_en_i(wr_en), .wr_data_i(wr_data), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .wr_ack_o(wr_ack));

  for (genvar g = 0; g < NP; g++) begin : g_port
    port_partner_model pm (.clock_i(clock_i), .reset_i(reset_i), .func_i(c_func[g]), .code_i(c_code),
      .volt_i(c_volt[g]), .res_i(c_res), .dly_i(c_dly), .wd_i(wd[g]), .st_i(st[g]), .evt_o(evt[g]));
  end

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task results;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task rd(input int p, input logic [3:0] s, input logic [7:0] e);
    port_sel <= p[1:0];
    reg_sel <= s;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock_i);
  endtask : rd

  task idle(input int n);
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    c_func <= '0;
    c_volt <= '0;
    repeat (n) @(posedge clock_i);
  endtask : idle

  task rd_all(input int p);
    rd(p, poe_status_pkg::SEL_DISC_LO, dv[p][7:0]);
    rd(p, poe_status_pkg::SEL_DISC_HI, {df[p], dv[p][14:8]});
    rd(p, poe_status_pkg::SEL_VOLT_LO, vv[p][7:0]);
    rd(p, poe_status_pkg::SEL_VOLT_HI, {vf[p], vv[p][14:8]});
    idle(1);
  endtask : rd_all

  task conv(input int p, input bit volt, input int dly, input logic [3:0] code);
    logic [14:0] r;
    int i;
    r = 15'($urandom);
    c_res <= r;
    c_dly <= dly[7:0];
    c_code <= code;
    if (volt) c_volt[p] <= 1'b1;
    else c_func[p] <= 1'b1;
    @(posedge clock_i);
    // a zero-delay done pulse is still visible here
    idle(2);
    if (volt) vf[p] = 1'b0;
    else df[p] = 1'b0;
    if (dly > 8) begin
      rd_all(p);
      rd(p, poe_status_pkg::SEL_STATUS2, {3'h0, wd[p], 1'b1, st[p]});
      idle(0);
    end
    for (i = 0; i < 300 && evt[p].conv_done !== 1'b1; i++) @(posedge clock_i);
    if (i == 300) begin
      err_count++;
      results();
    end
    if (volt) {vf[p], vv[p]} = {1'b1, r};
    else {df[p], dv[p]} = {1'b1, r};
    rd_all(p);
  endtask : conv

  always @(posedge clock_i) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected read", 8'h00, 8'hFF);
      else check("read data", rd_data, exp_q.pop_front());
    end
  end

  initial begin
    void'($urandom(76306));
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    for (int p = 0; p < NP; p++) begin
      for (int s = 0; s < 16; s++) rd(p, s[3:0], 8'h00);
    end
    idle(1);
    for (int c = 0; c < 8; c++) begin
      automatic int p = $urandom % NP;
      st[p] <= c[2:0];
      wd[p] <= 1'($urandom);
      idle(3);
      rd(p, poe_status_pkg::SEL_STATUS2, {3'h0, wd[p], 1'b0, st[p]});
      idle(1);
    end
    for (int p = 0; p < NP; p++) begin
      conv(p, 1'b0, 20 + $urandom % 30, poe_status_pkg::FUNC_DISC1);
      conv(p, 1'b0, 0, poe_status_pkg::FUNC_DISC2);
      conv(p, 1'b1, 25, 4'h3);
      conv(p, 1'b1, 0, 4'h3);
      for (int s = 5; s < 10; s++) begin
        port_sel <= p[1:0];
        reg_sel <= s[3:0];
        wr_data <= 8'($urandom);
        wr_en <= 1'b1;
        @(posedge clock_i);
        wr_en <= 1'b0;
        @(posedge clock_i);
        check("write ack", {7'h00, wr_ack}, 8'h01);
      end
      rd_all(p);
    end
    idle(4);
    check("pending reads", 8'(exp_q.size()), 8'h00);
    results();
  end
endmodule : poe_port_status_adc_results_tb

/* File: testbench/port_partner_model.sv */
// behavioural port control logic driving one port's events
`timescale 1ns/1ps
module port_partner_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // commands from the bench
  input wire logic func_i,
  input wire logic [3:0] code_i,
  input wire logic volt_i,
  input wire logic [14:0] res_i,
  input wire logic [7:0] dly_i,
  input wire logic wd_i,
  input wire logic [2:0] st_i,
  // events to the register bank
  output poe_status_pkg::port_evt_t evt_o
);
  logic [7:0] cnt_r;
  logic [14:0] res_r;
  logic volt_r;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      evt_o <= '0;
      cnt_r <= 8'h00;
      res_r <= 15'h0000;
      volt_r <= 1'b0;
    end else begin
      evt_o.func_wr <= func_i;
      evt_o.func_code <= code_i;
      evt_o.volt_start <= volt_i;
      evt_o.watchdog_active <= wd_i;
      evt_o.port_state <= st_i;
      evt_o.conv_done <= 1'b0;
      evt_o.conv_kind <= poe_status_pkg::CONV_NONE;
      // result bus changes every cycle outside the done pulse
      evt_o.conv_result <= ~evt_o.conv_result;
      if (func_i || volt_i) begin
        cnt_r <= dly_i;
        res_r <= res_i;
        volt_r <= volt_i;
        evt_o.adc_busy <= 1'b1;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end else if (evt_o.adc_busy) begin
        evt_o.conv_done <= 1'b1;
        evt_o.conv_kind <= volt_r ? poe_status_pkg::CONV_VOLT : poe_status_pkg::CONV_DISC;
        evt_o.conv_result <= res_r;
        evt_o.adc_busy <= 1'b0;
      end
    end
  end
endmodule : port_partner_model
